// ### hw/module_register_window_decoder.sv
// Register window decoder of the memory-and-logic module beside the core.
//
// Function
// - Decode 256-byte window at user-chosen base.
// - Pin-input reads return live port levels.
// - Ports A/B mode selects address output.
// - Output-value register drives output pins.
// - Direction register sets each pin's direction.
// - Drive type selects open-drain on ports A to D.
// - Enable-state reads show pin driver enables.
// - Offset 20h reads/loads logic cells group1.
// - Offset 21h reads/loads logic cells group2.
// - Write masks give masked cell bits the array value.
// - Read-only main flash sector lock status.
// - Read-only security and boot sector lock.
// - Space mapping places areas in program/data.
// - Page register extends address reach 256x.
// - Power manager powers down an idle core.
// - 16-bit address, 8-bit data, strobes.
// - Main flash has eight sector selects.
// - Boot flash has four sector selects.
// - Memory selects come from decode array only.
// - Core cannot reprogram arrays or configuration.
`timescale 1ns/1ps
`default_nettype none

module module_register_window_decoder
	import regwin_pkg::*;
#(
	parameter int PW = 8,
	parameter int IDLE_COUNT = IDLE_COUNT_DEFAULT
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic [7:0] I_WINDOW_BASE,
	input wire logic [15:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_RD_N,
	input wire logic I_WR_N,
	input wire logic I_FETCH_N,
	input wire logic I_ALE,
	input wire logic [PW-1:0] I_PORT_A,
	input wire logic [PW-1:0] I_PORT_B,
	input wire logic [PW-1:0] I_PORT_C,
	input wire logic [PW-1:0] I_PORT_D,
	input wire logic [PW-1:0] I_INPUT_CELLS_A,
	input wire logic [PW-1:0] I_INPUT_CELLS_B,
	input wire logic [PW-1:0] I_INPUT_CELLS_C,
	input wire logic [7:0] I_CELLS1_NEXT,
	input wire logic [7:0] I_CELLS2_NEXT,
	input wire logic [7:0] I_MAIN_SECTOR_LOCK,
	input wire logic [7:0] I_BOOT_SECTOR_LOCK,
	output logic [7:0] O_RDATA,
	output logic O_RVALID,
	output logic [PW-1:0] O_PORT_A,
	output logic [PW-1:0] O_PORT_A_OE,
	output logic [PW-1:0] O_PORT_B,
	output logic [PW-1:0] O_PORT_B_OE,
	output logic [PW-1:0] O_PORT_C,
	output logic [PW-1:0] O_PORT_C_OE,
	output logic [PW-1:0] O_PORT_D,
	output logic [PW-1:0] O_PORT_D_OE,
	output logic [4*PW-1:0] O_DRIVE_TYPE,
	output logic [7:0] O_CELLS1,
	output logic [7:0] O_CELLS2,
	output logic [7:0] O_PAGE,
	output logic [7:0] O_SPACE_MAP,
	output logic [7:0] O_PWR_CTRL0,
	output logic [7:0] O_PWR_CTRL2,
	output logic O_POWER_DOWN
);

	// ------------------------------------------------------------
	// Input synchronisers for pins and external status
	// ------------------------------------------------------------
	logic [4*PW-1:0] pin_s1_r, pin_s2_r;
	logic [3*PW-1:0] icell_s1_r, icell_s2_r;
	logic [31:0] lock_s1_r, lock_s2_r;

	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			icell_s1_r <= '0;
			icell_s2_r <= '0;
			lock_s1_r <= '0;
			lock_s2_r <= '0;
		end else begin
			pin_s1_r <= {I_PORT_D, I_PORT_C, I_PORT_B, I_PORT_A};
			pin_s2_r <= pin_s1_r;
			icell_s1_r <= {I_INPUT_CELLS_C, I_INPUT_CELLS_B, I_INPUT_CELLS_A};
			icell_s2_r <= icell_s1_r;
			lock_s1_r <= {I_CELLS2_NEXT, I_CELLS1_NEXT,
				I_BOOT_SECTOR_LOCK, I_MAIN_SECTOR_LOCK};
			lock_s2_r <= lock_s1_r;
		end
	end

	// ------------------------------------------------------------
	// Bus strobes and window decode
	// ------------------------------------------------------------
	core_bus_t bus;
	logic wr_d_r, rd_d_r;
	logic in_win, wr_pulse, rd_pulse;
	logic [7:0] ofs;

	assign bus = '{addr: I_ADDR, wdata: I_WDATA, rd_n: I_RD_N,
		wr_n: I_WR_N, fetch_n: I_FETCH_N, ale: I_ALE};
	assign in_win = (bus.addr[15:8] == I_WINDOW_BASE);
	assign ofs = bus.addr[7:0];
	// Writes act once, on the falling edge of the write strobe.
	assign wr_pulse = !bus.wr_n && wr_d_r && in_win && !bus.ale;
	// Program fetches never reach the register window.
	assign rd_pulse = !bus.rd_n && rd_d_r && bus.fetch_n && in_win;

	// ------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------
	logic [PW-1:0] mode_r [2];
	logic [PW-1:0] out_r [4];
	logic [PW-1:0] dir_r [4];
	logic [PW-1:0] drv_r [4];
	logic [7:0] cells_r [2];
	logic [7:0] mask_r [2];
	logic [7:0] pwr0_r, pwr2_r, page_r, vm_r;
	logic [PW-1:0] mode_nxt [2];
	logic [PW-1:0] out_nxt [4];
	logic [PW-1:0] dir_nxt [4];
	logic [PW-1:0] drv_nxt [4];
	logic [7:0] cells_nxt [2];
	logic [7:0] mask_nxt [2];
	logic [7:0] pwr0_nxt, pwr2_nxt, page_nxt, vm_nxt;

	always_comb begin
		mode_nxt = mode_r;
		out_nxt = out_r;
		dir_nxt = dir_r;
		drv_nxt = drv_r;
		mask_nxt = mask_r;
		pwr0_nxt = pwr0_r;
		pwr2_nxt = pwr2_r;
		page_nxt = page_r;
		vm_nxt = vm_r;
		// The logic array updates its cells, except the unmasked bits that the core loads.
		cells_nxt[0] = lock_s2_r[23:16];
		cells_nxt[1] = lock_s2_r[31:24];
		if (wr_pulse) begin
			case (ofs)
				OFS_A_MODE: mode_nxt[0] = bus.wdata[PW-1:0];
				OFS_B_MODE: mode_nxt[1] = bus.wdata[PW-1:0];
				OFS_A_OUT: out_nxt[0] = bus.wdata[PW-1:0];
				OFS_B_OUT: out_nxt[1] = bus.wdata[PW-1:0];
				OFS_C_OUT: out_nxt[2] = bus.wdata[PW-1:0];
				OFS_D_OUT: out_nxt[3] = bus.wdata[PW-1:0];
				OFS_A_DIR: dir_nxt[0] = bus.wdata[PW-1:0];
				OFS_B_DIR: dir_nxt[1] = bus.wdata[PW-1:0];
				OFS_C_DIR: dir_nxt[2] = bus.wdata[PW-1:0];
				OFS_D_DIR: dir_nxt[3] = bus.wdata[PW-1:0];
				OFS_A_DRV: drv_nxt[0] = bus.wdata[PW-1:0];
				OFS_B_DRV: drv_nxt[1] = bus.wdata[PW-1:0];
				OFS_C_DRV: drv_nxt[2] = bus.wdata[PW-1:0];
				OFS_D_DRV: drv_nxt[3] = bus.wdata[PW-1:0];
				OFS_CELLS1: begin
					cells_nxt[0] = (bus.wdata & ~mask_r[0])
						| (lock_s2_r[23:16] & mask_r[0]);
				end
				OFS_CELLS2: begin
					cells_nxt[1] = (bus.wdata & ~mask_r[1])
						| (lock_s2_r[31:24] & mask_r[1]);
				end
				OFS_MASK1: mask_nxt[0] = bus.wdata;
				OFS_MASK2: mask_nxt[1] = bus.wdata;
				OFS_PWR0: pwr0_nxt = bus.wdata;
				OFS_PWR2: pwr2_nxt = bus.wdata;
				OFS_PAGE: page_nxt = bus.wdata;
				OFS_SPACE_MAP: vm_nxt = bus.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			for (int i = 0; i < 4; i++) begin
				out_r[i] <= '0;
				dir_r[i] <= '0;
				drv_r[i] <= '0;
			end
			for (int i = 0; i < 2; i++) begin
				mode_r[i] <= '0;
				cells_r[i] <= RST_BYTE;
				mask_r[i] <= RST_BYTE;
			end
			pwr0_r <= RST_BYTE;
			pwr2_r <= RST_BYTE;
			page_r <= RST_BYTE;
			vm_r <= RST_SPACE_MAP;
			// Strobe history resets to the idle level, so that an access
			// starting at the first edge after reset is still taken.
			wr_d_r <= 1'b1;
			rd_d_r <= 1'b1;
		end else begin
			mode_r <= mode_nxt;
			out_r <= out_nxt;
			dir_r <= dir_nxt;
			drv_r <= drv_nxt;
			cells_r <= cells_nxt;
			mask_r <= mask_nxt;
			pwr0_r <= pwr0_nxt;
			pwr2_r <= pwr2_nxt;
			page_r <= page_nxt;
			vm_r <= vm_nxt;
			wr_d_r <= bus.wr_n;
			rd_d_r <= bus.rd_n;
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	logic [PW-1:0] pin_nxt [4];
	logic [PW-1:0] oe_nxt [4];
	logic [PW-1:0] pin_r [4];
	logic [PW-1:0] oe_r [4];

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_nxt[i] = out_r[i];
			oe_nxt[i] = dir_r[i];
		end
		// Ports A and B may drive the current core address inputs instead.
		for (int b = 0; b < PW; b++) begin
			if (mode_r[0][b]) begin
				pin_nxt[0][b] = bus.addr[b % 8];
				oe_nxt[0][b] = 1'b1;
			end
			if (mode_r[1][b]) begin
				pin_nxt[1][b] = bus.addr[8 + (b % 8)];
				oe_nxt[1][b] = 1'b1;
			end
		end
		// Open-drain pins only ever pull low.
		for (int i = 0; i < 4; i++) begin
			for (int b = 0; b < PW; b++) begin
				if (drv_r[i][b] && pin_nxt[i][b]) begin
					oe_nxt[i][b] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			for (int i = 0; i < 4; i++) begin
				pin_r[i] <= '0;
				oe_r[i] <= '0;
			end
		end else begin
			pin_r <= pin_nxt;
			oe_r <= oe_nxt;
		end
	end

	// ------------------------------------------------------------
	// Power manager
	// ------------------------------------------------------------
	pwr_state_t pwr_r, pwr_nxt;
	logic [$clog2(IDLE_COUNT+1)-1:0] idle_r, idle_nxt;
	logic activity;

	assign activity = !bus.rd_n || !bus.wr_n || !bus.fetch_n || bus.ale;

	always_comb begin
		pwr_nxt = pwr_r;
		idle_nxt = idle_r;
		case (pwr_r)
			PWR_RUN: begin
				if (activity || !pwr0_r[PWR0_AUTO_BIT]) begin
					idle_nxt = '0;
				end else if (idle_r ==
					($clog2(IDLE_COUNT+1))'(IDLE_COUNT)) begin
					pwr_nxt = PWR_DOWN;
				end else begin
					idle_nxt = idle_r + 1'b1;
				end
			end
			PWR_DOWN: begin
				if (activity || !pwr0_r[PWR0_AUTO_BIT]) begin
					pwr_nxt = PWR_RUN;
					idle_nxt = '0;
				end
			end
			default: pwr_nxt = PWR_RUN;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pwr_r <= PWR_RUN;
			idle_r <= '0;
		end else begin
			pwr_r <= pwr_nxt;
			idle_r <= idle_nxt;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [7:0] rdata_nxt, rdata_r;
	logic rvalid_r;

	always_comb begin
		rdata_nxt = 8'h00;
		case (ofs)
			OFS_A_PIN_IN: rdata_nxt[PW-1:0] = pin_s2_r[PW-1:0];
			OFS_B_PIN_IN: rdata_nxt[PW-1:0] = pin_s2_r[2*PW-1:PW];
			OFS_C_PIN_IN: rdata_nxt[PW-1:0] = pin_s2_r[3*PW-1:2*PW];
			OFS_D_PIN_IN: rdata_nxt[PW-1:0] = pin_s2_r[4*PW-1:3*PW];
			OFS_A_MODE: rdata_nxt[PW-1:0] = mode_r[0];
			OFS_B_MODE: rdata_nxt[PW-1:0] = mode_r[1];
			OFS_A_OUT: rdata_nxt[PW-1:0] = out_r[0];
			OFS_B_OUT: rdata_nxt[PW-1:0] = out_r[1];
			OFS_C_OUT: rdata_nxt[PW-1:0] = out_r[2];
			OFS_D_OUT: rdata_nxt[PW-1:0] = out_r[3];
			OFS_A_DIR: rdata_nxt[PW-1:0] = dir_r[0];
			OFS_B_DIR: rdata_nxt[PW-1:0] = dir_r[1];
			OFS_C_DIR: rdata_nxt[PW-1:0] = dir_r[2];
			OFS_D_DIR: rdata_nxt[PW-1:0] = dir_r[3];
			OFS_A_DRV: rdata_nxt[PW-1:0] = drv_r[0];
			OFS_B_DRV: rdata_nxt[PW-1:0] = drv_r[1];
			OFS_C_DRV: rdata_nxt[PW-1:0] = drv_r[2];
			OFS_D_DRV: rdata_nxt[PW-1:0] = drv_r[3];
			OFS_A_ICELL: rdata_nxt[PW-1:0] = icell_s2_r[PW-1:0];
			OFS_B_ICELL: rdata_nxt[PW-1:0] = icell_s2_r[2*PW-1:PW];
			OFS_C_ICELL: rdata_nxt[PW-1:0] = icell_s2_r[3*PW-1:2*PW];
			OFS_A_OE: rdata_nxt[PW-1:0] = oe_r[0];
			OFS_B_OE: rdata_nxt[PW-1:0] = oe_r[1];
			OFS_C_OE: rdata_nxt[PW-1:0] = oe_r[2];
			OFS_D_OE: rdata_nxt[PW-1:0] = oe_r[3];
			OFS_CELLS1: rdata_nxt = cells_r[0];
			OFS_CELLS2: rdata_nxt = cells_r[1];
			OFS_MASK1: rdata_nxt = mask_r[0];
			OFS_MASK2: rdata_nxt = mask_r[1];
			OFS_PWR0: rdata_nxt = pwr0_r;
			OFS_PWR2: rdata_nxt = pwr2_r;
			OFS_MAIN_LOCK: rdata_nxt = lock_s2_r[7:0];
			OFS_BOOT_LOCK: rdata_nxt = lock_s2_r[15:8];
			OFS_PAGE: rdata_nxt = page_r;
			OFS_SPACE_MAP: rdata_nxt = vm_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= rd_pulse;
			if (rd_pulse) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign O_RDATA = rdata_r;
	assign O_RVALID = rvalid_r;
	assign O_PORT_A = pin_r[0];
	assign O_PORT_A_OE = oe_r[0];
	assign O_PORT_B = pin_r[1];
	assign O_PORT_B_OE = oe_r[1];
	assign O_PORT_C = pin_r[2];
	assign O_PORT_C_OE = oe_r[2];
	assign O_PORT_D = pin_r[3];
	assign O_PORT_D_OE = oe_r[3];
	assign O_DRIVE_TYPE = {drv_r[3], drv_r[2], drv_r[1], drv_r[0]};
	assign O_CELLS1 = cells_r[0];
	assign O_CELLS2 = cells_r[1];
	// Page and space mapping feed the address decode array, which alone
	// forms the memory selects, so the core cannot alter the arrays here.
	assign O_PAGE = page_r;
	assign O_SPACE_MAP = vm_r;
	assign O_PWR_CTRL0 = pwr0_r;
	assign O_PWR_CTRL2 = pwr2_r;
	assign O_POWER_DOWN = (pwr_r == PWR_DOWN);

endmodule

`default_nettype wire

// ### inc/regwin_pkg.sv
// Package with register offsets, reset values and bus types of the window.
package regwin_pkg;

	// ------------------------------------------------------------
	// Register offsets within the window
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_A_PIN_IN = 8'h00;
	localparam logic [7:0] OFS_B_PIN_IN = 8'h01;
	localparam logic [7:0] OFS_A_MODE = 8'h02;
	localparam logic [7:0] OFS_B_MODE = 8'h03;
	localparam logic [7:0] OFS_A_OUT = 8'h04;
	localparam logic [7:0] OFS_B_OUT = 8'h05;
	localparam logic [7:0] OFS_A_DIR = 8'h06;
	localparam logic [7:0] OFS_B_DIR = 8'h07;
	localparam logic [7:0] OFS_A_DRV = 8'h08;
	localparam logic [7:0] OFS_B_DRV = 8'h09;
	localparam logic [7:0] OFS_A_ICELL = 8'h0a;
	localparam logic [7:0] OFS_B_ICELL = 8'h0b;
	localparam logic [7:0] OFS_A_OE = 8'h0c;
	localparam logic [7:0] OFS_B_OE = 8'h0d;
	localparam logic [7:0] OFS_C_PIN_IN = 8'h10;
	localparam logic [7:0] OFS_D_PIN_IN = 8'h11;
	localparam logic [7:0] OFS_C_OUT = 8'h12;
	localparam logic [7:0] OFS_D_OUT = 8'h13;
	localparam logic [7:0] OFS_C_DIR = 8'h14;
	localparam logic [7:0] OFS_D_DIR = 8'h15;
	localparam logic [7:0] OFS_C_DRV = 8'h16;
	localparam logic [7:0] OFS_D_DRV = 8'h17;
	localparam logic [7:0] OFS_C_ICELL = 8'h18;
	localparam logic [7:0] OFS_C_OE = 8'h1a;
	localparam logic [7:0] OFS_D_OE = 8'h1b;
	localparam logic [7:0] OFS_CELLS1 = 8'h20;
	localparam logic [7:0] OFS_CELLS2 = 8'h21;
	localparam logic [7:0] OFS_MASK1 = 8'h22;
	localparam logic [7:0] OFS_MASK2 = 8'h23;
	localparam logic [7:0] OFS_PWR0 = 8'hb0;
	localparam logic [7:0] OFS_PWR2 = 8'hb4;
	localparam logic [7:0] OFS_MAIN_LOCK = 8'hc0;
	localparam logic [7:0] OFS_BOOT_LOCK = 8'hc2;
	localparam logic [7:0] OFS_PAGE = 8'he0;
	localparam logic [7:0] OFS_SPACE_MAP = 8'he2;

	// ------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_SPACE_MAP = 8'h00;
	localparam int PWR0_AUTO_BIT = 1;
	localparam int IDLE_COUNT_DEFAULT = 255;

	// Core bus request, sampled on the system clock.
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic rd_n;
		logic wr_n;
		logic fetch_n;
		logic ale;
	} core_bus_t;

	// State of the automatic power-down logic.
	typedef enum logic [0:0] {
		PWR_RUN = 1'b0,
		PWR_DOWN = 1'b1
	} pwr_state_t;

endpackage

// ### sim/core_bus_model.sv
// Core bus model that issues byte reads and writes into the window.
`timescale 1ns/1ps
`default_nettype none
module core_bus_model
	import regwin_pkg::*;
(
	input wire logic clk,
	input wire logic rvalid,
	input wire logic [7:0] rdata,
	output var core_bus_t bus
);
	initial begin
		bus = '{16'h0000, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0};
	end
	// Calls start at a falling edge; a released data bus shows inverted data.
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input logic al);
		bus.addr = a;
		bus.wdata = d;
		bus.ale = al;
		bus.wr_n = 1'b0;
		@(posedge clk);
		@(negedge clk);
		bus.wr_n = 1'b1;
		bus.ale = 1'b0;
		bus.wdata = ~d;
		@(negedge clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic f,
		output logic [7:0] d, output logic v);
		bus.addr = a;
		bus.fetch_n = f;
		bus.rd_n = 1'b0;
		v = 1'b0;
		d = 8'h00;
		for (int n = 0; n < 3 && v !== 1'b1; n++) begin
			@(posedge clk);
			@(negedge clk);
			v = rvalid;
			d = rdata;
		end
		// Hold the strobe through the edge at which valid is sampled high.
		@(posedge clk);
		@(negedge clk);
		bus.rd_n = 1'b1;
		bus.fetch_n = 1'b1;
		@(negedge clk);
	endtask
	// Flash command prologue; it lands outside the register window.
	task automatic unlock();
		wr(16'h0555, 8'haa, 1'b0);
		wr(16'h0aaa, 8'h55, 1'b0);
	endtask
endmodule
`default_nettype wire

// ### sim/regwin_properties.sv
// Concurrent checks on the ports of the register window decoder.
`timescale 1ns/1ps
`default_nettype none
module regwin_properties
	import regwin_pkg::*;
#(
	parameter int IDLE_COUNT = IDLE_COUNT_DEFAULT
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic [7:0] I_WINDOW_BASE,
	input wire logic [15:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_RD_N,
	input wire logic I_WR_N,
	input wire logic I_FETCH_N,
	input wire logic I_ALE,
	input wire logic [7:0] O_RDATA,
	input wire logic O_RVALID,
	input wire logic [7:0] O_PAGE,
	input wire logic O_POWER_DOWN
);
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RSTN);
	logic hit;
	assign hit = I_ADDR[15:8] == I_WINDOW_BASE;
	a_read_answer: assert property (
		$fell(I_RD_N) && I_FETCH_N && hit |=> O_RVALID)
		else $error("window read got no answer");
	a_outside_quiet: assert property (
		$fell(I_RD_N) && !hit |=> !O_RVALID)
		else $error("read outside window answered");
	a_rvalid_cause: assert property (
		O_RVALID |-> !$past(I_RD_N) && $past(I_FETCH_N) && $past(hit))
		else $error("read valid without a window read");
	a_rvalid_pulse: assert property (
		O_RVALID |=> !O_RVALID)
		else $error("read valid longer than one cycle");
	a_rdata_hold: assert property (
		!O_RVALID |-> $stable(O_RDATA))
		else $error("read data changed without a read");
	a_empty_zero: assert property (
		$fell(I_RD_N) && I_FETCH_N && I_ADDR == {I_WINDOW_BASE, 8'h30}
		|=> O_RDATA == 8'h00)
		else $error("empty offset read not zero");
	a_page_load: assert property (
		$fell(I_WR_N) && !I_ALE && I_ADDR == {I_WINDOW_BASE, OFS_PAGE}
		|=> O_PAGE == $past(I_WDATA))
		else $error("page register not loaded");
	a_ale_write_ignored: assert property (
		$fell(I_WR_N) && I_ALE |=> $stable(O_PAGE))
		else $error("write with latch strobe high took effect");
	a_power_wake: assert property (
		O_POWER_DOWN && !I_RD_N |-> ##[1:3] !O_POWER_DOWN)
		else $error("strobe did not wake power-down");
	c_read: cover property ($fell(I_RD_N) && hit);
	c_down: cover property ($rose(O_POWER_DOWN));
	c_ale: cover property ($fell(I_WR_N) && I_ALE);
endmodule
bind module_register_window_decoder regwin_properties #(
	.IDLE_COUNT(IDLE_COUNT)) u_props (.I_CLK_SYS(I_CLK_SYS),
	.I_RSTN(I_RSTN), .I_WINDOW_BASE(I_WINDOW_BASE), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_RD_N(I_RD_N), .I_WR_N(I_WR_N),
	.I_FETCH_N(I_FETCH_N), .I_ALE(I_ALE), .O_RDATA(O_RDATA),
	.O_RVALID(O_RVALID), .O_PAGE(O_PAGE), .O_POWER_DOWN(O_POWER_DOWN));
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the register window decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import regwin_pkg::*;
	localparam logic [7:0] BASE = 8'h7f;
	localparam int IDLE = 4;
	localparam logic [7:0] RWO [19] = '{OFS_A_MODE, OFS_B_MODE, OFS_A_OUT,
		OFS_B_OUT, OFS_C_OUT, OFS_D_OUT, OFS_A_DIR, OFS_B_DIR, OFS_C_DIR,
		OFS_D_DIR, OFS_A_DRV, OFS_B_DRV, OFS_C_DRV, OFS_D_DRV, OFS_MASK1,
		OFS_MASK2, OFS_PWR2, OFS_PAGE, OFS_SPACE_MAP};
	localparam logic [7:0] RO [9] = '{OFS_A_PIN_IN, OFS_B_PIN_IN,
		OFS_C_PIN_IN, OFS_D_PIN_IN, OFS_A_ICELL, OFS_B_ICELL, OFS_C_ICELL,
		OFS_MAIN_LOCK, OFS_BOOT_LOCK};
	localparam logic [7:0] EMPTY [4] = '{8'h30, 8'h19, 8'hff, 8'h0e};
	logic clk, rstn, rv, pd;
	logic [7:0] base, rdat, pg, vm, p0, p2, c1, c2;
	logic [7:0] in_v [11];
	logic [7:0] pa, pao, pb, pbo, pc, pco, pdd, pdo;
	logic [31:0] drv;
	core_bus_t bus;
	int mismatches = 0;
	int num_checks = 0;
	core_bus_model core (.clk(clk), .rvalid(rv), .rdata(rdat), .bus(bus));
	module_register_window_decoder #(.PW(8), .IDLE_COUNT(IDLE)) DUT (
		.I_CLK_SYS(clk), .I_RSTN(rstn), .I_WINDOW_BASE(base),
		.I_ADDR(bus.addr), .I_WDATA(bus.wdata), .I_RD_N(bus.rd_n),
		.I_WR_N(bus.wr_n), .I_FETCH_N(bus.fetch_n), .I_ALE(bus.ale),
		.I_PORT_A(in_v[0]), .I_PORT_B(in_v[1]), .I_PORT_C(in_v[2]),
		.I_PORT_D(in_v[3]), .I_INPUT_CELLS_A(in_v[4]),
		.I_INPUT_CELLS_B(in_v[5]), .I_INPUT_CELLS_C(in_v[6]),
		.I_MAIN_SECTOR_LOCK(in_v[7]), .I_BOOT_SECTOR_LOCK(in_v[8]),
		.I_CELLS1_NEXT(in_v[9]), .I_CELLS2_NEXT(in_v[10]),
		.O_RDATA(rdat), .O_RVALID(rv), .O_PORT_A(pa), .O_PORT_A_OE(pao),
		.O_PORT_B(pb), .O_PORT_B_OE(pbo), .O_PORT_C(pc), .O_PORT_C_OE(pco),
		.O_PORT_D(pdd), .O_PORT_D_OE(pdo), .O_DRIVE_TYPE(drv),
		.O_CELLS1(c1), .O_CELLS2(c2), .O_PAGE(pg), .O_SPACE_MAP(vm),
		.O_PWR_CTRL0(p0), .O_PWR_CTRL2(p2), .O_POWER_DOWN(pd));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	// Read one offset; a refused read must leave valid low.
	task automatic rq(input logic [15:0] a, input logic f, input logic ev,
		input logic [7:0] e);
		logic [7:0] d;
		logic v;
		core.rd(a, f, d, v);
		chk("rvalid", {7'h00, ev}, {7'h00, v});
		if (ev) begin
			chk("rdata", e, d);
		end
	endtask
	// Write a cell group and look at its flip-flops just after the edge.
	task automatic cw(input logic [7:0] o, input logic [7:0] d,
		input logic [7:0] e);
		fork
			core.wr({BASE, o}, d, 1'b0);
			begin
				@(posedge clk);
				@(negedge clk);
				chk("cells", e, (o == OFS_CELLS1) ? c1 : c2);
			end
		join
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		test_done;
	end
	initial begin
		rstn = 1'b0;
		base = BASE;
		for (int i = 0; i < 11; i++) in_v[i] = 8'h00;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		for (int i = 0; i < 19; i++) begin
			core.wr({BASE, RWO[i]}, RWO[i] ^ 8'ha5, 1'b0);
		end
		for (int i = 0; i < 19; i++) begin
			rq({BASE, RWO[i]}, 1'b1, 1'b1, RWO[i] ^ 8'ha5);
		end
		chk("page", OFS_PAGE ^ 8'ha5, pg);
		chk("space_map", OFS_SPACE_MAP ^ 8'ha5, vm);
		chk("pwr2", OFS_PWR2 ^ 8'ha5, p2);
		chk("pwr0", 8'h00, p0);
		chk("port_c", OFS_C_OUT ^ 8'ha5, pc);
		chk("port_d", OFS_D_OUT ^ 8'ha5, pdd);
		// Every driving bit of ports C and D is an open-drain one here.
		chk("port_c_oe", 8'h00, pco);
		chk("port_d_oe", 8'h00, pdo);
		chk("drive_type", OFS_D_DRV ^ 8'ha5, drv[31:24]);
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		for (int i = 0; i < 19; i++) begin
			rq({BASE, RWO[i]}, 1'b1, 1'b1, RST_BYTE);
		end
		$display("test registers done");
		for (int i = 0; i < 11; i++) in_v[i] = 8'(17 * (i + 1));
		repeat (3) @(negedge clk);
		core.wr({BASE, OFS_MAIN_LOCK}, 8'h00, 1'b0);
		core.wr({BASE, 8'h30}, 8'hff, 1'b0);
		for (int i = 0; i < 9; i++) begin
			rq({BASE, RO[i]}, 1'b1, 1'b1, 8'(17 * (i + 1)));
		end
		for (int i = 0; i < 4; i++) begin
			rq({BASE, EMPTY[i]}, 1'b1, 1'b1, 8'h00);
		end
		rq({BASE, OFS_CELLS1}, 1'b1, 1'b1, 8'haa);
		rq({BASE, OFS_CELLS2}, 1'b1, 1'b1, 8'hbb);
		rq({BASE + 8'h01, OFS_PAGE}, 1'b1, 1'b0, 8'h00);
		rq({BASE, OFS_PAGE}, 1'b0, 1'b0, 8'h00);
		core.wr({BASE, OFS_PAGE}, 8'h77, 1'b1);
		core.wr({BASE ^ 8'h01, OFS_PAGE}, 8'h66, 1'b0);
		core.unlock();
		rq(16'h8000, 1'b0, 1'b0, 8'h00);
		chk("page", 8'h00, pg);
		$display("test reads done");
		core.wr({BASE, OFS_A_DIR}, 8'hff, 1'b0);
		core.wr({BASE, OFS_A_OUT}, 8'ha5, 1'b0);
		repeat (2) @(negedge clk);
		chk("port_a", 8'ha5, pa);
		chk("port_a_oe", 8'hff, pao);
		chk("port_b_oe", 8'h00, pbo);
		rq({BASE, OFS_A_OE}, 1'b1, 1'b1, 8'hff);
		core.wr({BASE, OFS_A_DRV}, 8'h0f, 1'b0);
		repeat (2) @(negedge clk);
		chk("drive_type", 8'h0f, drv[7:0]);
		chk("port_a_oe", 8'hfa, pao);
		rq({BASE, OFS_A_OE}, 1'b1, 1'b1, 8'hfa);
		core.wr({BASE, OFS_A_MODE}, 8'hff, 1'b0);
		repeat (2) @(negedge clk);
		// Pins now carry address byte 02h; open-drain bit 1 stops driving.
		chk("port_a", 8'h02, pa);
		chk("port_a_oe", 8'hfd, pao);
		core.wr({BASE, OFS_MASK1}, 8'hf0, 1'b0);
		cw(OFS_CELLS1, 8'h55, 8'ha5);
		cw(OFS_CELLS2, 8'h3c, 8'h3c);
		$display("test ports done");
		core.wr({BASE, OFS_PWR0}, 8'(1 << PWR0_AUTO_BIT), 1'b0);
		repeat (IDLE + 6) @(negedge clk);
		chk("power_down", 8'h01, {7'h00, pd});
		rq({BASE, OFS_PWR0}, 1'b1, 1'b1, 8'(1 << PWR0_AUTO_BIT));
		chk("power_down", 8'h00, {7'h00, pd});
		$display("test power done");
		test_done;
	end
endmodule
`default_nettype wire
